// ### vacs_map.svh
/*
 * Constants of the voice alarm call sequencer: prompt sections, key codes,
 * time windows and counts.
 * Assumes it is included by the package and by the design modules.
 */
`ifndef VACS_MAP_SVH
`define VACS_MAP_SVH

// ****************************************************************
// Clock and time windows
// ****************************************************************
`define VACS_CLK_HZ 125000000
`define VACS_SEC_CYCLES (`VACS_CLK_HZ * 1)
`define VACS_PW_WIN_S 7'd9
`define VACS_ANSWER_S 7'd40
`define VACS_REDIAL_S 7'd20

// ****************************************************************
// Prompt sections and key codes
// ****************************************************************
`define VACS_SEC_IDENT 7'h00
`define VACS_SEC_ACCEPT 7'h01
`define VACS_SEC_REJECT 7'h02
`define VACS_SEC_DIALED 7'h03
`define VACS_SEC_ALARM 7'h04
`define VACS_SEC_FIRST_USER 7'h04
`define VACS_KEY_STAR 4'hA
`define VACS_KEY_HASH 4'hB
`define VACS_PW_DIGITS 3'd4
`define VACS_WRONG_LIMIT 2'd2
`define VACS_PW_RESET 16'h0000

`endif

// ### vacs_pkg.sv
/*
 * Types of the voice alarm call sequencer.
 * Assumes vacs_map.svh is on the include path.
 */
`include "vacs_map.svh"

package vacs_pkg;

  // ****************************************************************
  // Sequencer states and carriers
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_DIAL, ST_PROMPT, ST_COLLECT,
    ST_ACCEPT, ST_REJECT, ST_CONTROL, ST_REDIAL
  } vacs_state_t;

  // Decoded tone key: 0..9 digits, A star, B hash
  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } vacs_key_t;

  // Prompt player request
  typedef struct packed {
    logic on;
    logic start;
    logic [6:0] sec;
  } vacs_play_t;

endpackage : vacs_pkg

// ### vacs_tick.sv
/*
 * One-second tick generator for the call sequencer.
 * Assumes a free-running clock; the tick is a one-cycle pulse.
 */
`timescale 1ns/1ps
`include "vacs_map.svh"

module vacs_tick #(
  parameter int unsigned CYCLES = `VACS_SEC_CYCLES
) (
  input wire logic clk, // System clock
  input wire logic rst, // Async reset, active high
  output logic tick_q // One pulse per second
);
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic tick_d;

  // ****************************************************************
  // Divider
  // ****************************************************************
  // Wraps after CYCLES clocks
  always_comb begin
    tick_d = (cnt_q == CYCLES - 1);
    cnt_d = tick_d ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end

  // Divider registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  a_tick_period: assert property (@(posedge clk) disable iff (rst)
    tick_q |=> !tick_q) else $error("tick longer than one cycle");
endmodule : vacs_tick

// ### vacs_sequencer.sv
/*
 * Call and password sequencer of the telephone voice alarm unit.
 * Assumes a tone decoder and prompt player on the same clock; ring and
 * answer detection arrive as raw pins.
 */
// What this block does
// - Sections zero to three are system prompts
// - Section zero only on incoming calls
// - Section one only after correct password
// - Section two on the first two mismatches
// - Section three when device dialled out
// - Incoming call: off-hook, prompt, await password
// - Incoming mismatch: reject, then repeat section zero
// - Outgoing call plays alarm message with three
// - Outgoing correct: one, repeat alarm, allow control
// - Outgoing wrong: two, alternate three and four
// - Outgoing: abandon after 40 s without password
// - Abandoned call redials every 20 s
// - Star stops playback, four digits in 9 s
// - Window expiry replays prompt, star needed again
// - Third wrong password hangs up, stops playback
// - After outgoing wrong-password hang-up, redial while alarm
// - Alarm message played once at the start of each redial wait
// - Digits count as code only after star
// - Two hashes in a row hang up
`timescale 1ns/1ps
`include "vacs_map.svh"

module vacs_sequencer
  import vacs_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `VACS_SEC_CYCLES,
  parameter logic [6:0] ALARM_SEC = `VACS_SEC_ALARM
) (
  input wire logic clk, // System clock, 125 MHz
  input wire logic rst, // Async reset, active high
  input wire logic ring_in, // Incoming ring detect pin
  input wire logic answer_in, // Far end answered pin
  input wire vacs_key_t key_in, // Decoded tone key
  input wire logic alarm_in, // Alarm condition from controller
  input wire logic [15:0] pw_value, // Stored password, four BCD digits
  input wire logic play_done, // Prompt player finished section
  output logic hook_off_q, // Line held off-hook
  output logic dial_q, // Pulse: dial preset number
  output vacs_play_t play_q, // Prompt player request
  output logic ctrl_valid_q, // Pulse: control code received
  output logic [3:0] ctrl_code_q // Control digit
);
  // Alarm message kept out of the system sections
  localparam logic [6:0] ALARM_PLAY =
    (ALARM_SEC < `VACS_SEC_FIRST_USER) ? `VACS_SEC_FIRST_USER : ALARM_SEC;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic is_digit(input logic [3:0] c);
    is_digit = (c <= 4'h9);
  endfunction : is_digit

  function automatic logic [6:0] sat_inc(input logic [6:0] v, input logic t);
    sat_inc = (t && v != 7'h7F) ? v + 7'h01 : v;
  endfunction : sat_inc

  logic ring_m_q, ring_s_q, ans_m_q, ans_s_q;
  logic tick;
  vacs_state_t state_q, state_d;
  logic out_q, out_d, ok_q, ok_d, star_q, star_d, hash_q, hash_d, alt_q, alt_d;
  logic alarm_q;
  logic [1:0] wrong_q, wrong_d;
  logic [2:0] ndig_q, ndig_d;
  logic [15:0] pw_q, pw_d;
  logic [6:0] sec_q, sec_d, call_q, call_d;
  logic hook_d, dial_d, cv_d;
  logic [3:0] cc_d;
  vacs_play_t play_d;
  logic is_star, is_hash, is_dig, hang, redial, abandon, pw_full;
  logic [15:0] pw_next;

  // ****************************************************************
  // Pin synchronisers and second tick
  // ****************************************************************
  // Two stages per pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ring_m_q <= 1'b0;
      ring_s_q <= 1'b0;
      ans_m_q <= 1'b0;
      ans_s_q <= 1'b0;
    end else begin
      ring_m_q <= ring_in;
      ring_s_q <= ring_m_q;
      ans_m_q <= answer_in;
      ans_s_q <= ans_m_q;
    end
  end

  vacs_tick #(.CYCLES(SEC_CYCLES)) u_tick (
    .clk(clk),
    .rst(rst),
    .tick_q(tick)
  );

  // ****************************************************************
  // Call sequencing
  // ****************************************************************
  // Key decode and shared conditions
  always_comb begin
    is_star = key_in.valid && key_in.code == `VACS_KEY_STAR;
    is_hash = key_in.valid && key_in.code == `VACS_KEY_HASH;
    is_dig = key_in.valid && is_digit(key_in.code);
    pw_next = {pw_q[11:0], key_in.code};
    pw_full = is_dig && ndig_q == `VACS_PW_DIGITS - 3'd1;
    abandon = out_q && !ok_q && call_q >= `VACS_ANSWER_S;
  end

  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    out_d = out_q;
    ok_d = ok_q;
    star_d = star_q;
    hash_d = hash_q;
    alt_d = alt_q;
    wrong_d = wrong_q;
    ndig_d = ndig_q;
    pw_d = pw_q;
    hook_d = hook_off_q;
    dial_d = 1'b0;
    cv_d = 1'b0;
    cc_d = ctrl_code_q;
    play_d = play_q;
    play_d.start = 1'b0;
    hang = 1'b0;
    redial = 1'b0;
    case (state_q)
      ST_IDLE, ST_REDIAL: begin
        if (ring_s_q) begin
          // Answer, identity prompt, fresh attempt count
          state_d = ST_PROMPT;
          hook_d = 1'b1;
          out_d = 1'b0;
          ok_d = 1'b0;
          wrong_d = 2'd0;
          play_d = '{on: 1'b1, start: 1'b1, sec: `VACS_SEC_IDENT};
        end else if (state_q == ST_IDLE && alarm_in && !alarm_q) begin
          state_d = ST_DIAL;
          dial_d = 1'b1;
          out_d = 1'b1;
          ok_d = 1'b0;
          wrong_d = 2'd0;
        end else if (state_q == ST_REDIAL && !alarm_in) begin
          state_d = ST_IDLE;
        end else if (state_q == ST_REDIAL && sec_q >= `VACS_REDIAL_S) begin
          state_d = ST_DIAL;
          dial_d = 1'b1;
          out_d = 1'b1;
          ok_d = 1'b0;
          wrong_d = 2'd0;
        end
      end
      ST_DIAL: begin
        if (abandon) begin
          redial = 1'b1;
        end else if (ans_s_q) begin
          // Connected: alarm message first, then dialled-out prompt
          state_d = ST_PROMPT;
          hook_d = 1'b1;
          alt_d = 1'b1;
          play_d = '{on: 1'b1, start: 1'b1, sec: ALARM_PLAY};
        end
      end
      ST_PROMPT, ST_REJECT: begin
        if (is_star) begin
          // Stop playback and open the password window
          state_d = ST_COLLECT;
          ndig_d = 3'd0;
          play_d.on = 1'b0;
        end else if (play_done && play_q.on) begin
          play_d.start = 1'b1;
          state_d = ST_PROMPT;
          if (!out_q) begin
            play_d.sec = `VACS_SEC_IDENT;
          end else begin
            alt_d = !alt_q;
            play_d.sec = alt_q ? `VACS_SEC_DIALED : ALARM_PLAY;
          end
        end
      end
      ST_COLLECT: begin
        if (sec_q >= `VACS_PW_WIN_S) begin
          // Window lapsed: replay prompt, star required again
          state_d = ST_PROMPT;
          alt_d = 1'b1;
          play_d = '{on: 1'b1, start: 1'b1, sec: out_q ? `VACS_SEC_DIALED : `VACS_SEC_IDENT};
        end else if (is_dig) begin
          pw_d = pw_next;
          ndig_d = ndig_q + 3'd1;
          if (pw_full && pw_next == pw_value) begin
            state_d = ST_ACCEPT;
            ok_d = 1'b1;
            play_d = '{on: 1'b1, start: 1'b1, sec: `VACS_SEC_ACCEPT};
          end else if (pw_full && wrong_q == `VACS_WRONG_LIMIT) begin
            hang = 1'b1;
            redial = out_q;
          end else if (pw_full) begin
            state_d = ST_REJECT;
            wrong_d = wrong_q + 2'd1;
            alt_d = 1'b1;
            play_d = '{on: 1'b1, start: 1'b1, sec: `VACS_SEC_REJECT};
          end
        end
      end
      ST_ACCEPT, ST_CONTROL: begin
        if (play_done && play_q.on) begin
          state_d = ST_CONTROL;
          play_d.on = out_q;
          play_d.start = out_q;
          play_d.sec = ALARM_PLAY;
        end
        if (state_q == ST_CONTROL && key_in.valid) begin
          // Star then digit forms a control code
          star_d = is_star;
          if (star_q && is_dig) begin
            cv_d = 1'b1;
            cc_d = key_in.code;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (hook_off_q && key_in.valid) begin
      hash_d = is_hash;
      if (hash_q && is_hash) begin
        hang = 1'b1;
      end
    end
    if (abandon && state_q != ST_DIAL && state_q != ST_IDLE && state_q != ST_REDIAL) begin
      redial = 1'b1;
    end
    if (hang || redial) begin
      state_d = (redial && alarm_in) ? ST_REDIAL : ST_IDLE;
      hook_d = 1'b0;
      hash_d = 1'b0;
      star_d = 1'b0;
      play_d = '{on: 1'b0, start: 1'b0, sec: play_q.sec};
    end
    if (state_d == ST_REDIAL && state_q != ST_REDIAL) begin
      // Local alarm broadcast each redial period
      play_d = '{on: 1'b1, start: 1'b1, sec: ALARM_PLAY};
    end
  end

  // Timers: per-state seconds and outgoing call seconds
  always_comb begin
    sec_d = (state_d != state_q) ? 7'h00 : sat_inc(sec_q, tick);
    call_d = dial_d ? 7'h00 : sat_inc(call_q, tick);
  end

  // Sequencer registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      out_q <= 1'b0;
      ok_q <= 1'b0;
      star_q <= 1'b0;
      hash_q <= 1'b0;
      alt_q <= 1'b0;
      alarm_q <= 1'b0;
      wrong_q <= 2'd0;
      ndig_q <= 3'd0;
      pw_q <= `VACS_PW_RESET;
      sec_q <= 7'h00;
      call_q <= 7'h00;
      hook_off_q <= 1'b0;
      dial_q <= 1'b0;
      play_q <= '0;
      ctrl_valid_q <= 1'b0;
      ctrl_code_q <= 4'h0;
    end else begin
      state_q <= state_d;
      out_q <= out_d;
      ok_q <= ok_d;
      star_q <= star_d;
      hash_q <= hash_d;
      alt_q <= alt_d;
      alarm_q <= alarm_in;
      wrong_q <= wrong_d;
      ndig_q <= ndig_d;
      pw_q <= pw_d;
      sec_q <= sec_d;
      call_q <= call_d;
      hook_off_q <= hook_d;
      dial_q <= dial_d;
      play_q <= play_d;
      ctrl_valid_q <= cv_d;
      ctrl_code_q <= cc_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_accept_on_match: assert property (
    state_q == ST_COLLECT && sec_q < `VACS_PW_WIN_S && pw_full && pw_next == pw_value
    |=> play_q.start && play_q.sec == `VACS_SEC_ACCEPT && ok_q) else $error("no accept prompt");
  a_accept_needs_ok: assert property (
    play_q.start && play_q.sec == `VACS_SEC_ACCEPT |-> ok_q) else $error("accept before password");
  a_ident_incoming: assert property (
    play_q.start && play_q.sec == `VACS_SEC_IDENT |-> !out_q) else $error("ident on outgoing call");
  a_third_wrong_hang: assert property (
    state_q == ST_COLLECT && sec_q < `VACS_PW_WIN_S && pw_full && pw_next != pw_value
    && wrong_q == 2'd2 |=> !hook_off_q && (!play_q.on || state_q == ST_REDIAL)) else $error("no hang-up on third");
  a_star_stops_play: assert property (
    state_q == ST_PROMPT && is_star && !hang && !abandon |=> state_q == ST_COLLECT && !play_q.on)
    else $error("star did not stop playback");
  a_window_expiry: assert property (
    state_q == ST_COLLECT && sec_q >= `VACS_PW_WIN_S && !hang && !abandon
    |=> state_q == ST_PROMPT ##1 state_q != ST_COLLECT || $past(is_star)) else $error("window ignored");
  a_hash_hangup: assert property (
    hook_off_q && hash_q && is_hash |=> !hook_off_q) else $error("double hash kept line");
  a_wrong_cleared: assert property (
    $rose(hook_off_q) |-> wrong_q == 2'd0) else $error("wrong count not cleared");
  a_ring_answer: assert property (
    state_q == ST_IDLE && ring_s_q |=> hook_off_q && play_q.on) else $error("ring not answered");
  a_abandon_call: assert property (
    state_q == ST_DIAL && abandon |=> !hook_off_q && state_q != ST_DIAL
    && (!play_q.on || state_q == ST_REDIAL && play_q.sec == ALARM_PLAY)) else $error("call not abandoned");
endmodule : vacs_sequencer

// ### vacs_phone_model.sv
/*
 * Caller model: keys tones and picks up outgoing calls.
 * Assumes the sequencer clock; keys change 1 ns after an edge.
 */
`timescale 1ns/1ps
`include "vacs_map.svh"

module vacs_phone_model
  import vacs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic dial, // Dial pulse from sequencer
  input wire logic hook_off, // Line state from sequencer
  output vacs_key_t key_out, // Keyed tone
  output logic answer_out // Far end picked up
);
  // ********
  // Keying and answering
  // ********
  logic ans_en = 1'b0;

  initial begin
    key_out = '0;
    answer_out = 1'b0;
  end

  // One key for one cycle, code scrambled while idle
  task automatic press(input logic [3:0] c);
    @(posedge clk);
    #1 key_out = {1'b1, c};
    @(posedge clk);
    #1 key_out = {1'b0, ~c};
  endtask : press

  // Four digits, first one from the top nibble
  task automatic digits(input logic [15:0] v);
    for (int i = 3; i >= 0; i--) press(v[i*4 +: 4]);
  endtask : digits

  // Star prefix, then the code
  task automatic pw(input logic [15:0] v);
    press(`VACS_KEY_STAR);
    digits(v);
  endtask : pw

  // Pick up 10 cycles after a dial, drop on hang-up
  always @(posedge clk) begin
    if (dial && ans_en) begin
      repeat (10) @(posedge clk);
      #1 answer_out = 1'b1;
      @(negedge hook_off);
      #1 answer_out = 1'b0;
    end
  end
endmodule : vacs_phone_model

// ### test_voice_alarm_call_sequencer.sv
/*
 * Self-checking bench of the call sequencer.
 * Assumes a short second (SC cycles) and a prompt player driven here.
 */
`timescale 1ns/1ps
`include "vacs_map.svh"

module test_voice_alarm_call_sequencer
  import vacs_pkg::*;
;
  // ********
  // Bench signals
  // ********
  localparam int SC = 20;
  localparam logic [15:0] PW = 16'h2165;
  localparam logic [15:0] BAD = 16'h2166;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ring_in = 1'b0;
  logic alarm_in = 1'b0;
  logic play_done = 1'b0;
  logic answer_in, hook_off_q, dial_q, ctrl_valid_q;
  logic [3:0] ctrl_code_q;
  vacs_key_t key_in;
  vacs_play_t play_q;
  int n_fail = 0;
  int n_compared = 0;
  int n_cyc;
  logic hit;

  always #4 clk = ~clk;

  vacs_sequencer #(.SEC_CYCLES(SC)) i_dut (.clk(clk), .rst(rst), .ring_in(ring_in),
    .answer_in(answer_in), .key_in(key_in), .alarm_in(alarm_in), .pw_value(PW),
    .play_done(play_done), .hook_off_q(hook_off_q), .dial_q(dial_q), .play_q(play_q),
    .ctrl_valid_q(ctrl_valid_q), .ctrl_code_q(ctrl_code_q));

  vacs_phone_model i_phone (.clk(clk), .dial(dial_q), .hook_off(hook_off_q),
    .key_out(key_in), .answer_out(answer_in));

  // ********
  // Shared tasks
  // ********
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (e !== g) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  function automatic logic sig(input int w);
    case (w)
      0: return play_q.start;
      1: return dial_q;
      2: return hook_off_q;
      default: return ctrl_valid_q;
    endcase
  endfunction : sig

  // Bounded wait for one output to reach a level
  // Looks before the first edge: a pulse launched by the last edge still counts
  task automatic await(input string nm, input int w, input logic e, input int lim);
    n_cyc = 0;
    while (sig(w) !== e && n_cyc < lim) begin
      tick(1);
      n_cyc++;
    end
    chk(nm, e, sig(w));
  endtask : await

  task automatic expect_sec(input logic [6:0] s, input int lim);
    await("play_start", 0, 1'b1, lim);
    chk("play_sec", s, play_q.sec);
  endtask : expect_sec

  task automatic done();
    play_done = 1'b1;
    tick(1);
    play_done = 1'b0;
  endtask : done

  task automatic ring();
    ring_in = 1'b1;
    expect_sec(`VACS_SEC_IDENT, 10);
    chk("hook_off", 1, hook_off_q);
    ring_in = 1'b0;
  endtask : ring

  // ********
  // Scenarios
  // ********
  task automatic t_in_wrong();
    ring();
    for (int i = 0; i < 3; i++) begin
      i_phone.pw(BAD);
      if (i < 2) begin
        expect_sec(`VACS_SEC_REJECT, 10);
        done();
        expect_sec(`VACS_SEC_IDENT, 5);
      end
    end
    await("hook_off", 2, 1'b0, 10);
    chk("play_on", 0, play_q.on);
  endtask : t_in_wrong

  task automatic t_in_ok();
    ring();
    i_phone.press(`VACS_KEY_STAR);
    tick(2);
    chk("play_on", 0, play_q.on);
    expect_sec(`VACS_SEC_IDENT, 11 * SC);
    chk("window", 1, n_cyc >= 8 * SC);
    i_phone.pw(BAD);
    expect_sec(`VACS_SEC_REJECT, 10);
    done();
    i_phone.pw(PW);
    expect_sec(`VACS_SEC_ACCEPT, 10);
    done();
    tick(2);
    chk("play_on", 0, play_q.on);
    i_phone.press(4'h5);
    tick(2);
    chk("ctrl_code", 0, ctrl_code_q);
    i_phone.press(`VACS_KEY_STAR);
    i_phone.press(4'h7);
    await("ctrl_valid", 3, 1'b1, 5);
    chk("ctrl_code", 4'h7, ctrl_code_q);
    i_phone.press(`VACS_KEY_HASH);
    i_phone.press(`VACS_KEY_HASH);
    await("hook_off", 2, 1'b0, 10);
  endtask : t_in_ok

  task automatic t_out();
    i_phone.ans_en = 1'b1;
    alarm_in = 1'b1;
    await("dial", 1, 1'b1, 5);
    expect_sec(`VACS_SEC_ALARM, 30);
    chk("hook_off", 1, hook_off_q);
    done();
    expect_sec(`VACS_SEC_DIALED, 5);
    i_phone.pw(BAD);
    expect_sec(`VACS_SEC_REJECT, 10);
    done();
    expect_sec(`VACS_SEC_DIALED, 5);
    done();
    expect_sec(`VACS_SEC_ALARM, 5);
    i_phone.pw(PW);
    expect_sec(`VACS_SEC_ACCEPT, 10);
    done();
    expect_sec(`VACS_SEC_ALARM, 5);
    done();
    expect_sec(`VACS_SEC_ALARM, 5);
    i_phone.press(`VACS_KEY_STAR);
    i_phone.press(4'h3);
    await("ctrl_valid", 3, 1'b1, 5);
    chk("ctrl_code", 4'h3, ctrl_code_q);
    i_phone.press(`VACS_KEY_HASH);
    i_phone.press(`VACS_KEY_HASH);
    await("hook_off", 2, 1'b0, 10);
    alarm_in = 1'b0;
    i_phone.ans_en = 1'b0;
    tick(5);
  endtask : t_out

  task automatic t_abandon();
    alarm_in = 1'b1;
    await("dial", 1, 1'b1, 5);
    expect_sec(`VACS_SEC_ALARM, 45 * SC);
    chk("abandon_time", 1, n_cyc >= 39 * SC && n_cyc <= 41 * SC + 5);
    await("redial", 1, 1'b1, 22 * SC);
    chk("redial_time", 1, n_cyc >= 19 * SC && n_cyc <= 21 * SC + 5);
    expect_sec(`VACS_SEC_ALARM, 45 * SC);
    alarm_in = 1'b0;
    hit = 1'b0;
    repeat (25 * SC) begin
      tick(1);
      if (dial_q !== 1'b0) hit = 1'b1;
    end
    chk("dial_after_clear", 0, hit);
  endtask : t_abandon

  task automatic stop_test();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    tick(2);
    t_in_wrong();
    t_in_ok();
    t_out();
    t_abandon();
    stop_test();
  end

  // Watchdog against a hang
  initial begin
    repeat (12000) @(posedge clk);
    n_fail++;
    stop_test();
  end
endmodule : test_voice_alarm_call_sequencer
